// *** inc/serial_consts.svh ***
// Constants for the serial port: offsets, field positions, codes and timing
`ifndef SERIAL_CONSTS_SVH
`define SERIAL_CONSTS_SVH

// Port select: low address bit picks command/status (1) or data (0)
`define SEL_CTRL_BIT     0
`define SEL_UPPER_BIT    1

// Line format word fields
`define FMT_LEN_LSB      2
`define FMT_LEN_MSB      3
`define FMT_PAR_EN_BIT   4
`define FMT_PAR_EVEN_BIT 5
`define FMT_STOP_LSB     6
`define FMT_STOP_MSB     7
`define FMT_RST          8'h00

// Operation command codes
`define CMD_TX_ON        8'h33
`define CMD_RX_ON        8'h36
`define CMD_BOTH_ON      8'h37
`define CMD_SOFT_RESET   8'h40

// Line status bits
`define ST_TX_EMPTY      0
`define ST_RX_AVAIL      1
`define ST_TX_MODE       2
`define ST_PAR_ERR       3
`define ST_OVERRUN       4
`define ST_FRAME_ERR     5
`define ST_UNUSED        6
`define ST_REV_CHAN      7

// Timing: clock rate in Hz, baud in bit/s, bit time derived in cycles
`define CLK_HZ           10000000
`define BAUD_RATE        9600
`define BIT_CYC          (`CLK_HZ / `BAUD_RATE)
`define HALF_CYC         (`BIT_CYC / 2)
`define CNT_W            12

`endif

// *** inc/serial_pkg.sv ***
// Types shared by the serial port design
`default_nettype none
package serial_pkg;

  typedef logic [7:0] byte_t;

  // Gray codes along idle, start, data, parity, stop
  typedef enum logic [2:0]
  {
    FS_IDLE   = 3'b000,
    FS_START  = 3'b001,
    FS_DATA   = 3'b011,
    FS_PARITY = 3'b010,
    FS_STOP   = 3'b110
  } frame_state_t;

endpackage
`default_nettype wire

// *** core/byte_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides
`default_nettype none
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t n;
  logic        push;
  logic        pop;

  assign in_ready  = (q.cnt != (AW+1)'(D));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rp];

  always_comb
  begin
    n    = q;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push)
    begin
      n.mem[q.wp] = in_data;
      n.wp        = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop)
      n.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
    if (push && !pop)
      n.cnt = q.cnt + 1'b1;
    else if (pop && !push)
      n.cnt = q.cnt - 1'b1;
    if (flush)
    begin
      n.wp  = '0;
      n.rp  = '0;
      n.cnt = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      q <= '0;
    else
      q <= n;
  end
endmodule
`default_nettype wire

// *** core/serial_port.sv ***
// Programmable serial transmitter/receiver reached through two I/O ports
// Function
// - Odd address status/command, even address data
// - Lower pair decoded, strap enables upper pair
// - First command write is format, next command
// - Format bits 3:2 give five to eight
// - Format bit 4 enables parity bit
// - Format bit 5: odd clear, even set
// - Format bits 7:6 give stop length
// - Codes 33, 36, 37 enable functions
// - Code 40 resets, format expected again
// - Later command writes change enables anytime
// - Command address read returns status byte
// - Bit 0 transmit space, cleared when FIFO full
// - Bit 1 character ready, cleared by read
// - Bit 2 set while transmitter enabled
// - Bit 3 parity error of last character
// - Bit 4 overrun, character not read
// - Bit 5 framing error, stop missing
// - Bit 7 reverse channel, bit 6 zero
// - Each line bit but the stop lasts one bit time
`include "serial_consts.svh"
`default_nettype none
module serial_port (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              port_sel,
  input  wire logic [1:0]        addr,
  input  wire logic              upper_en,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  input  wire serial_pkg::byte_t wdata,
  output serial_pkg::byte_t      rdata,
  output logic                   txd,
  input  wire logic              rxd,
  input  wire logic              rev_chan
);
  import serial_pkg::*;

  typedef struct packed {
    logic         fmt_set;
    byte_t        fmt;
    logic         tx_en;
    logic         rx_en;
    byte_t        rdata;
    byte_t        rx_data;
    logic         rx_avail;
    logic         par_err;
    logic         ovr_err;
    logic         frm_err;
    logic         rev;
    logic         txd;
    frame_state_t tx_st;
    logic [`CNT_W-1:0] tx_cnt;
    logic [2:0]   tx_bit;
    byte_t        tx_sh;
    logic         tx_par;
    frame_state_t rx_st;
    logic [`CNT_W-1:0] rx_cnt;
    logic [2:0]   rx_bit;
    byte_t        rx_sh;
    logic         rx_par;
  } port_state_t;

  localparam logic [`CNT_W-1:0] BIT_LAST  = `CNT_W'(`BIT_CYC - 1);
  localparam logic [`CNT_W-1:0] HALF_LAST = `CNT_W'(`HALF_CYC - 1);

  port_state_t q;
  port_state_t n;
  logic        hit;
  logic        soft_rst;
  logic        data_rd;
  logic        rx_done;
  byte_t       status;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  byte_t       fifo_out_data;
  logic [`CNT_W-1:0] tx_last;
  byte_t       rx_word;

  // Character length, five to eight
  function automatic logic [3:0] char_len(input byte_t f);
    char_len = 4'd5 + {2'b00, f[`FMT_LEN_MSB:`FMT_LEN_LSB]};
  endfunction

  // Parity bit that makes the count of ones odd or even
  function automatic logic par_bit(input byte_t d, input byte_t f);
    byte_t m;
    m = 8'hff >> (4'd8 - char_len(f));
    par_bit = (^(d & m)) ^ ~f[`FMT_PAR_EVEN_BIT];
  endfunction

  // Stop time in cycles, counted in half bits; the illegal code acts as one stop
  function automatic logic [`CNT_W-1:0] stop_last(input byte_t f);
    logic [2:0] halves;
    unique case (f[`FMT_STOP_MSB:`FMT_STOP_LSB])
      2'b10:   halves = 3'd3;
      2'b11:   halves = 3'd4;
      default: halves = 3'd2;
    endcase
    stop_last = `CNT_W'(halves * `HALF_CYC - 1);
  endfunction

  byte_fifo #(
    .W (8),
    .D (8)
  ) u_tx_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .flush     (soft_rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (wdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign hit     = port_sel && (!addr[`SEL_UPPER_BIT] || upper_en);
  assign data_rd = hit && rd_stb && !addr[`SEL_CTRL_BIT];
  assign status  = {q.rev, 1'b0, q.frm_err, q.ovr_err, q.par_err,
                    q.tx_en, q.rx_avail, fifo_in_ready};
  assign tx_last = (q.tx_st == FS_STOP) ? stop_last(q.fmt) : BIT_LAST;
  assign rx_word = q.rx_sh >> (4'd8 - char_len(q.fmt));
  assign rdata   = q.rdata;
  assign txd     = q.txd;

  always_comb
  begin
    n              = q;
    soft_rst       = 1'b0;
    fifo_in_valid  = 1'b0;
    fifo_out_ready = 1'b0;
    rx_done        = 1'b0;
    n.rev          = rev_chan;

    // Host writes
    if (hit && wr_stb)
    begin
      if (!addr[`SEL_CTRL_BIT])
        fifo_in_valid = 1'b1;
      else if (!q.fmt_set)
      begin
        n.fmt     = wdata;
        n.fmt_set = 1'b1;
      end
      else
      begin
        // Unlisted codes leave the enables as they are
        case (wdata)
          `CMD_TX_ON:
          begin
            n.tx_en = 1'b1;
            n.rx_en = 1'b0;
          end
          `CMD_RX_ON:
          begin
            n.tx_en = 1'b0;
            n.rx_en = 1'b1;
          end
          `CMD_BOTH_ON:
          begin
            n.tx_en = 1'b1;
            n.rx_en = 1'b1;
          end
          `CMD_SOFT_RESET:
            soft_rst = 1'b1;
          default:
            n.tx_en = q.tx_en;
        endcase
      end
    end

    // Host reads
    if (hit && rd_stb)
    begin
      n.rdata = addr[`SEL_CTRL_BIT] ? status : q.rx_data;
      if (!addr[`SEL_CTRL_BIT])
        n.rx_avail = 1'b0;
    end

    // Transmitter; a disable lets the frame in flight finish
    if (q.tx_st != FS_IDLE)
      n.tx_cnt = q.tx_cnt + 1'b1;
    unique case (q.tx_st)
      FS_IDLE:
      begin
        n.txd = 1'b1;
        if (q.tx_en && fifo_out_valid)
        begin
          fifo_out_ready = 1'b1;
          n.tx_sh  = fifo_out_data;
          n.tx_par = par_bit(fifo_out_data, q.fmt);
          n.tx_st  = FS_START;
          n.tx_cnt = '0;
          n.txd    = 1'b0;
        end
      end
      FS_START, FS_DATA, FS_PARITY, FS_STOP:
      begin
        if (q.tx_cnt == tx_last)
        begin
          n.tx_cnt = '0;
          if (q.tx_st == FS_START)
          begin
            n.tx_st  = FS_DATA;
            n.tx_bit = '0;
            n.txd    = q.tx_sh[0];
          end
          else if (q.tx_st == FS_DATA && {1'b0, q.tx_bit} != char_len(q.fmt) - 4'd1)
          begin
            n.tx_bit = q.tx_bit + 1'b1;
            n.tx_sh  = q.tx_sh >> 1;
            n.txd    = q.tx_sh[1];
          end
          else if (q.tx_st == FS_DATA && q.fmt[`FMT_PAR_EN_BIT])
          begin
            n.tx_st = FS_PARITY;
            n.txd   = q.tx_par;
          end
          else if (q.tx_st == FS_STOP)
            n.tx_st = FS_IDLE;
          else
          begin
            n.tx_st = FS_STOP;
            n.txd   = 1'b1;
          end
        end
      end
      default:
        n.tx_st = FS_IDLE;
    endcase

    // Receiver, samples each bit in its middle
    if (q.rx_st != FS_IDLE)
      n.rx_cnt = q.rx_cnt + 1'b1;
    unique case (q.rx_st)
      FS_IDLE:
      begin
        if (q.rx_en && !rxd)
        begin
          n.rx_st  = FS_START;
          n.rx_cnt = '0;
        end
      end
      FS_START:
      begin
        // A start shorter than half a bit is taken as noise
        if (q.rx_cnt == HALF_LAST)
        begin
          n.rx_cnt = '0;
          n.rx_bit = '0;
          n.rx_st  = rxd ? FS_IDLE : FS_DATA;
        end
      end
      FS_DATA:
      begin
        if (q.rx_cnt == BIT_LAST)
        begin
          n.rx_cnt = '0;
          n.rx_sh  = {rxd, q.rx_sh[7:1]};
          n.rx_bit = q.rx_bit + 1'b1;
          if ({1'b0, q.rx_bit} == char_len(q.fmt) - 4'd1)
            n.rx_st = q.fmt[`FMT_PAR_EN_BIT] ? FS_PARITY : FS_STOP;
        end
      end
      FS_PARITY:
      begin
        if (q.rx_cnt == BIT_LAST)
        begin
          n.rx_cnt = '0;
          n.rx_par = rxd;
          n.rx_st  = FS_STOP;
        end
      end
      FS_STOP:
      begin
        if (q.rx_cnt == BIT_LAST)
        begin
          rx_done   = 1'b1;
          n.rx_st   = FS_IDLE;
          n.rx_data = rx_word;
          n.par_err = q.fmt[`FMT_PAR_EN_BIT] && (q.rx_par != par_bit(rx_word, q.fmt));
          n.frm_err = !rxd;
          n.ovr_err = q.ovr_err || n.rx_avail;
          n.rx_avail = 1'b1;
        end
      end
      default:
        n.rx_st = FS_IDLE;
    endcase

    // Internal reset returns to the power-on state, keeping the read latch
    if (soft_rst)
    begin
      n          = '0;
      n.txd      = 1'b1;
      n.rdata    = q.rdata;
      n.rev      = rev_chan;
      n.fmt      = `FMT_RST;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      q       <= '0;
      q.txd   <= 1'b1;
      q.fmt   <= `FMT_RST;
    end
    else
      q <= n;
  end

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  property p_data_read;
    hit && rd_stb && !addr[0] |=> rdata == $past(q.rx_data) && !q.rx_avail || $past(rx_done);
  endproperty
  a_data_read: assert property (p_data_read) else $error("data read mismatch");

  property p_upper_blocked;
    port_sel && addr[1] && !upper_en && wr_stb |=> $stable(q.fmt) && $stable(q.tx_en) && $stable(q.fmt_set);
  endproperty
  a_upper_blocked: assert property (p_upper_blocked) else $error("upper pair not ignored");

  property p_first_is_format;
    hit && wr_stb && addr[0] && !q.fmt_set |=> q.fmt_set && q.fmt == $past(wdata) && !q.tx_en;
  endproperty
  a_first_is_format: assert property (p_first_is_format) else $error("format word not taken");

  property p_both_on;
    hit && wr_stb && addr[0] && q.fmt_set && wdata == `CMD_BOTH_ON |=> q.tx_en && q.rx_en && status[2];
  endproperty
  a_both_on: assert property (p_both_on) else $error("enable command failed");

  property p_soft_reset;
    hit && wr_stb && addr[0] && q.fmt_set && wdata == `CMD_SOFT_RESET |=> !q.fmt_set && !q.tx_en && !q.rx_en && txd;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("internal reset failed");

  property p_status_read;
    hit && rd_stb && addr[0] |=> rdata == $past(status) && !rdata[6];
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read mismatch");

  property p_overrun;
    rx_done && q.rx_avail && !data_rd |=> q.ovr_err && q.rx_avail;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_start_bit;
    q.tx_st == FS_IDLE && q.tx_en && fifo_out_valid |=> !txd [*8];
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit not low");

  property p_idle_high;
    q.tx_st == FS_IDLE ##1 q.tx_st == FS_IDLE |-> txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle line not high");

  property p_write_full;
    hit && wr_stb && !addr[0] && !fifo_in_ready |=> !status[0] || q.tx_st == FS_START;
  endproperty
  a_write_full: assert property (p_write_full) else $error("empty flag wrong");

  c_init: cover property (q.fmt_set ##1 q.tx_en && q.rx_en);
  c_rx_char: cover property (rx_done && !q.frm_err);
  c_tx_frame: cover property (q.tx_st == FS_STOP ##1 q.tx_st == FS_IDLE);
  c_overrun: cover property (q.ovr_err);
endmodule
`default_nettype wire

// *** verification/serial_peer.sv ***
// Far end of the serial line: sends frames on rxd and checks frames seen on txd
`include "serial_consts.svh"
`default_nettype none
module serial_peer (
  input  wire logic mclk,
  input  wire logic txd,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  int         nbits = 8;
  int         halves = 2;
  logic       par_en = 1'b0;
  logic       par_even = 1'b0;
  logic [8:0] got;
  event       frame_done;

  task automatic setup(input logic [7:0] f);
    nbits = 5 + int'({f[3], f[2]});
    par_en = f[4];
    par_even = f[5];
    halves = (f[7:6] == 2'b10) ? 3 : (f[7:6] == 2'b11) ? 4 : 2;
  endtask

  function automatic logic pbit(input logic [7:0] d);
    return ^(d & 8'((1 << nbits) - 1)) ^ !par_even;
  endfunction

  task automatic hold(input logic v, input int n);
    rxd = v;
    repeat (n) @(negedge mclk);
  endtask

  // Wrong parity or a low stop go out only when a scenario asks for them
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    @(negedge mclk);
    hold(1'b0, `BIT_CYC);
    for (int i = 0; i < nbits; i++)
      hold(d[i], `BIT_CYC);
    if (par_en)
      hold(pbit(d) ^ bad_par, `BIT_CYC);
    hold(!bad_stop, halves * `HALF_CYC);
    hold(1'b1, `BIT_CYC);
  endtask

  initial
  begin
    logic ok;
    rxd = 1'b1;
    forever
    begin
      @(negedge txd);
      ok = 1'b1;
      got = '0;
      repeat (`HALF_CYC) @(posedge mclk);
      ok &= !txd;
      for (int i = 0; i < nbits; i++)
      begin
        repeat (`BIT_CYC) @(posedge mclk);
        got[i] = txd;
      end
      if (par_en)
      begin
        repeat (`BIT_CYC) @(posedge mclk);
        ok &= (txd == pbit(got[7:0]));
      end
      repeat (`BIT_CYC) @(posedge mclk);
      ok &= txd;
      // Late sample near the end of the configured stop span
      repeat ((halves - 1) * `HALF_CYC - 20) @(posedge mclk);
      ok &= txd;
      got[8] = ok;
      -> frame_done;
    end
  end
endmodule
`default_nettype wire

// *** verification/serial_port_bench.sv ***
// Self-checking bench for the serial port: host accesses, line frames, FIFO
`default_nettype none
module serial_port_bench;
  import serial_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, reset, port_sel, upper_en, wr_stb, rd_stb, rev_chan, rxd, txd;
  logic [1:0]  addr;
  byte_t       wdata, rdata;
  logic [15:0] lfsr_q = 16'h4d7f;
  int          n_mismatch = 0;
  int          n_compared = 0;
  logic        look = 1'b0;
  logic        pend = 1'b0;
  logic [15:0] rd_e;
  logic [15:0] rdq[$];
  logic [8:0]  txq[$];
  byte_t       codes[3] = '{8'h33, 8'h36, 8'h37};

  serial_port serial_port_inst (.mclk(mclk), .reset(reset), .port_sel(port_sel), .addr(addr),
    .upper_en(upper_en), .wr_stb(wr_stb), .rd_stb(rd_stb), .wdata(wdata), .rdata(rdata),
    .txd(txd), .rxd(rxd), .rev_chan(rev_chan));
  serial_peer serial_peer_inst (.mclk(mclk), .txd(txd), .rxd(rxd));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic byte_t rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q[7:0];
  endfunction

  task automatic wr(input logic [1:0] a, input byte_t d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    wr_stb = 1'b1;
    @(negedge mclk);
    wr_stb = 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input byte_t exp, input byte_t mask);
    @(negedge mclk);
    addr = a;
    rd_stb = 1'b1;
    pend = 1'b1;
    rdq.push_back({mask, exp & mask});
    @(negedge mclk);
    rd_stb = 1'b0;
    pend = 1'b0;
    @(negedge mclk);
  endtask

  task automatic st(input byte_t b);
    rd(2'd1, {rev_chan, b[6:0]}, 8'hff);
  endtask

  task automatic put(input byte_t d, input logic keep);
    wr(2'd0, d);
    if (keep)
      txq.push_back({1'b1, d & byte_t'((1 << serial_peer_inst.nbits) - 1)});
  endtask

  task automatic drain;
    for (int i = 0; i < 80000 && txq.size() != 0; i++)
      @(negedge mclk);
  endtask

  // Read data is judged one edge after the take edge, when rdata has settled
  always @(posedge mclk)
  begin
    if (look)
    begin
      rd_e = rdq.pop_front();
      check("read data", {8'h00, rd_e[7:0]}, {8'h00, rdata & rd_e[15:8]});
    end
    look <= pend;
  end

  always @(serial_peer_inst.frame_done)
    check("line frame", {7'h00, txq.pop_front()}, {7'h00, serial_peer_inst.got});

  initial
  begin
    #(98000 * 100);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    byte_t d;
    {reset, port_sel, upper_en, wr_stb, rd_stb, rev_chan} = 6'b110000;
    addr = 2'd0;
    wdata = 8'h00;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    st(8'h01);
    wr(2'd1, 8'h52);
    serial_peer_inst.setup(8'h52);
    wr(2'd1, 8'h36);
    st(8'h01);
    for (int i = 0; i < 9; i++)
    begin
      d = rnd();
      put(d, i < 8);
      if (i == 7)
        st(8'h00);
    end
    port_sel = 1'b0;
    wr(2'd1, 8'h40);
    port_sel = 1'b1;
    wr(2'd3, 8'h40);
    wr(2'd1, 8'h37);
    repeat (4) @(negedge mclk);
    rev_chan = 1'b1;
    upper_en = 1'b1;
    rd(2'd3, 8'h85, 8'hff);
    upper_en = 1'b0;
    $display("test format, fifo and decode done");
    d = rnd();
    serial_peer_inst.send(d, 1'b0, 1'b0);
    st(8'h87);
    rd(2'd0, d, 8'h1f);
    st(8'h85);
    serial_peer_inst.send(d, 1'b0, 1'b1);
    st(8'ha7);
    rd(2'd0, d, 8'h1f);
    serial_peer_inst.send(d, 1'b0, 1'b0);
    serial_peer_inst.send(d ^ 8'h0a, 1'b0, 1'b0);
    st(8'h97);
    drain();
    // The last stop ends a few cycles after its frame is judged
    repeat (100) @(negedge mclk);
    $display("test five-bit odd line done");
    wr(2'd1, 8'h40);
    wr(2'd1, 8'hbe);
    serial_peer_inst.setup(8'hbe);
    wr(2'd1, 8'h37);
    d = rnd();
    fork
      put(d, 1'b1);
      serial_peer_inst.send(d ^ 8'h5a, 1'b1, 1'b0);
    join
    drain();
    st(8'h8f);
    rd(2'd0, d ^ 8'h5a, 8'hff);
    foreach (codes[i])
    begin
      wr(2'd1, codes[i]);
      rd(2'd1, {5'h00, codes[i] != 8'h36, 2'b00}, 8'h04);
    end
    $display("test eight-bit even line done");
    // Parity off and two stops reach the paths the other formats never take
    wr(2'd1, 8'h40);
    wr(2'd1, 8'hca);
    serial_peer_inst.setup(8'hca);
    wr(2'd1, 8'h37);
    d = rnd();
    fork
      put(d, 1'b1);
      serial_peer_inst.send(d ^ 8'h33, 1'b0, 1'b0);
    join
    drain();
    st(8'h87);
    rd(2'd0, d ^ 8'h33, 8'h7f);
    $display("test seven-bit plain line done");
    complete_run();
  end
endmodule
`default_nettype wire
